// >>> ibtx_exec.sv
// Purpose: executes indicator, branch, transmit and move-flag instructions
// Assumes: storage answers the registered read with rdata in that same cycle
// Notes: start is taken only while busy is low
`timescale 1ns/1ps
`default_nettype none
module ibtx_exec (
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    input  wire logic                     reset_key,
    input  wire logic                     start,
    input  wire ibtx_pkg::ibtx_instr_type instr,
    input  wire ibtx_pkg::ibtx_event_type events,
    input  wire ibtx_pkg::ibtx_digit_type mem_rdata,
    output logic                          busy,
    output logic                          done,
    output logic                          branch_taken,
    output ibtx_pkg::ibtx_mem_req_type    mem_req,
    output logic [18:0]                   indicators
);
    import ibtx_pkg::*;

    // indicators bit order: 06,07,09,11,12,13,16,17,19,36,37,38,39,42 minus summaries stored
    typedef enum {
        IDLE, READ_Q, WAIT_Q, WRITE_P, MF_READ_P, MF_WAIT_P, MF_WRITE, TIMING
    } ibtx_state_type;

    ibtx_state_type       state;
    ibtx_instr_type       cur;
    logic [ADDR_W-1:0]    p_ptr;
    logic [ADDR_W-1:0]    q_ptr;
    logic [2:0]           imm_idx;
    ibtx_digit_type       src;
    logic [CNT_W-1:0]     cycles;
    logic [CNT_W-1:0]     wait_cnt;
    logic                 ind_rd, ind_wr, ind_card, ind_hp, ind_ez, ind_even, ind_odd;
    logic                 ind_addr, ind_len, ind_cyl, ind_seek;
    logic                 test_strobe;
    logic [7:0]           test_code;

    // ==========================================================
    // indicator lookup
    function automatic logic ind_value(input logic [7:0] code);
        logic disk_any;
        disk_any = ind_addr | ind_len | ind_cyl;
        unique case (code)
            IND_RD_CHECK:  ind_value = ind_rd;
            IND_WR_CHECK:  ind_value = ind_wr;
            IND_LAST_CARD: ind_value = ind_card;
            IND_HIGH_POS:  ind_value = ind_hp;
            IND_EQ_ZERO:   ind_value = ind_ez;
            IND_HP_OR_EZ:  ind_value = ind_hp | ind_ez;
            IND_EVEN_CHK:  ind_value = ind_even;
            IND_ODD_CHK:   ind_value = ind_odd;
            IND_ANY_CHECK: ind_value = ind_rd | ind_wr | ind_even | ind_odd | disk_any;
            IND_ADDR_CHK:  ind_value = ind_addr;
            IND_WRONG_LEN: ind_value = ind_len;
            IND_CYL_OVF:   ind_value = ind_cyl;
            IND_ANY_DISK:  ind_value = disk_any;
            IND_SEEK_DONE: ind_value = ind_seek;
            default:       ind_value = 1'b0;
        endcase
    endfunction

    function automatic logic is_start_ok(input logic s, input logic b);
        is_start_ok = s & ~b;
    endfunction

    // ==========================================================
    // indicators: set wins over clear; summary codes clear nothing
    wire logic clr_rd   = test_strobe && test_code == IND_RD_CHECK;
    wire logic clr_wr   = test_strobe && test_code == IND_WR_CHECK;
    wire logic clr_card = test_strobe && test_code == IND_LAST_CARD;
    wire logic clr_even = test_strobe && test_code == IND_EVEN_CHK;
    wire logic clr_odd  = test_strobe && test_code == IND_ODD_CHK;
    wire logic clr_addr = (test_strobe && test_code == IND_ADDR_CHK) || events.disk_start;
    wire logic clr_len  = (test_strobe && test_code == IND_WRONG_LEN) || events.disk_start;
    wire logic clr_cyl  = (test_strobe && test_code == IND_CYL_OVF) || events.disk_start;
    wire logic clr_seek = test_strobe && test_code == IND_SEEK_DONE;
    wire logic cyl_set  = events.last_sector && events.sector_cnt_nonzero;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ind_hp <= 1'b0;
            ind_ez <= 1'b0;
        end else if (events.arith_done) begin
            ind_hp <= events.result_pos && !events.result_zero;
            ind_ez <= events.result_zero;
        end else if (reset_key) begin
            ind_hp <= 1'b0;
            ind_ez <= 1'b0;
        end
    end

    // summary codes 13, 19 and 39 match no clear term above
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ind_rd   <= 1'b0;
            ind_wr   <= 1'b0;
            ind_card <= 1'b0;
            ind_even <= 1'b0;
            ind_odd  <= 1'b0;
            ind_addr <= 1'b0;
            ind_len  <= 1'b0;
            ind_cyl  <= 1'b0;
        end else begin
            ind_rd   <= events.read_err  || (ind_rd  && !(clr_rd  || reset_key));
            ind_wr   <= events.write_err || (ind_wr  && !(clr_wr  || reset_key));
            ind_card <= events.last_card || (ind_card && !(clr_card || reset_key));
            ind_even <= events.even_parity_err || (ind_even && !(clr_even || reset_key));
            ind_odd  <= events.odd_parity_err  || (ind_odd  && !(clr_odd  || reset_key));
            ind_addr <= events.disk_addr_err || (ind_addr && !(clr_addr || reset_key));
            ind_len  <= events.disk_len_err  || (ind_len  && !(clr_len  || reset_key));
            ind_cyl  <= cyl_set || (ind_cyl && !(clr_cyl || reset_key));
        end
    end

    // seek complete survives the reset key; only a test of code 42 or power-on reset clears it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ind_seek <= 1'b0;
        end else begin
            ind_seek <= events.seek_end || (ind_seek && !clr_seek);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            indicators <= '0;
        end else begin
            // bit 17 has no indicator behind it and reads zero
            indicators <= {ind_seek, 1'b0,
                           ind_addr | ind_len | ind_cyl, ind_cyl, ind_len, ind_addr,
                           ind_rd | ind_wr | ind_even | ind_odd | ind_addr | ind_len | ind_cyl,
                           ind_odd, ind_even, ind_hp | ind_ez, ind_ez, ind_hp,
                           ind_card, ind_wr, ind_rd, 4'h0};
        end
    end

    // ==========================================================
    // sequencer
    // one instruction at a time; start is ignored until done has pulsed
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= IDLE;
            cur          <= '0;
            p_ptr        <= '0;
            q_ptr        <= '0;
            imm_idx      <= '0;
            src          <= '0;
            cycles       <= '0;
            wait_cnt     <= '0;
            busy         <= 1'b0;
            done         <= 1'b0;
            branch_taken <= 1'b0;
            mem_req      <= '0;
            test_strobe  <= 1'b0;
            test_code    <= '0;
        end else begin
            done        <= 1'b0;
            test_strobe <= 1'b0;
            mem_req.rd  <= 1'b0;
            mem_req.wr  <= 1'b0;
            wait_cnt    <= wait_cnt + 1'b1;
            unique case (state)
                IDLE: begin
                    if (is_start_ok(start, busy)) begin
                        cur          <= instr;
                        p_ptr        <= instr.p_addr;
                        q_ptr        <= instr.q_addr;
                        imm_idx      <= '0;
                        busy         <= 1'b1;
                        branch_taken <= 1'b0;
                        wait_cnt     <= '0;
                        unique case (instr.op)
                            IBTX_OP_BRANCH_ON, IBTX_OP_BRANCH_OFF: begin
                                test_code   <= {instr.q_digits[3].value,
                                                instr.q_digits[2].value};
                                test_strobe <= 1'b1;
                                branch_taken <= ind_value({instr.q_digits[3].value,
                                    instr.q_digits[2].value}) ^
                                    (instr.op == IBTX_OP_BRANCH_OFF);
                                cycles <= (ind_value({instr.q_digits[3].value,
                                    instr.q_digits[2].value}) ^
                                    (instr.op == IBTX_OP_BRANCH_OFF)) ?
                                    CNT_W'(CYC_SHORT) : CNT_W'(CYC_BASE);
                                state  <= TIMING;
                            end
                            // immediate forms skip the storage read and write from the instruction
                            IBTX_OP_XMIT_DIGIT_IMM: begin
                                src    <= instr.q_digits[0];
                                cycles <= CNT_W'(CYC_SHORT);
                                state  <= WRITE_P;
                            end
                            IBTX_OP_XMIT_FIELD_IMM: begin
                                src    <= instr.q_digits[0];
                                cycles <= CNT_W'(CYC_BASE);
                                state  <= WRITE_P;
                            end
                            IBTX_OP_NONE: begin
                                busy   <= 1'b0;
                                done   <= 1'b1;
                            end
                            default: begin
                                cycles <= (instr.op == IBTX_OP_XMIT_FIELD ||
                                           instr.op == IBTX_OP_XMIT_RECORD) ?
                                          CNT_W'(CYC_BASE) : CNT_W'(CYC_SHORT);
                                state  <= READ_Q;
                            end
                        endcase
                    end
                end
                READ_Q: begin
                    mem_req.rd   <= 1'b1;
                    mem_req.addr <= q_ptr;
                    state        <= WAIT_Q;
                end
                WAIT_Q: begin
                    // storage answers the registered read in the same cycle
                    state <= (cur.op == IBTX_OP_MOVE_FLAG) ? MF_READ_P : WRITE_P;
                    src   <= mem_rdata;
                    unique case (cur.op)
                        IBTX_OP_BRANCH_NO_GROUP: begin
                            branch_taken <= mem_rdata.value != GROUP_MARK;
                            cycles <= (mem_rdata.value != GROUP_MARK) ?
                                      CNT_W'(CYC_LONG) : CNT_W'(CYC_SHORT);
                            state  <= TIMING;
                        end
                        IBTX_OP_BRANCH_NO_RECORD: begin
                            // group mark carries the same 8 and 2 bits
                            branch_taken <= (mem_rdata.value & MARK_BITS) != MARK_BITS;
                            cycles <= ((mem_rdata.value & MARK_BITS) != MARK_BITS) ?
                                      CNT_W'(CYC_LONG) : CNT_W'(CYC_SHORT);
                            state  <= TIMING;
                        end
                        default: begin
                        end
                    endcase
                end
                WRITE_P: begin
                    mem_req.wr    <= 1'b1;
                    mem_req.addr  <= p_ptr;
                    mem_req.wdata <= src;
                    state         <= TIMING;
                    if (cur.op == IBTX_OP_XMIT_FIELD || cur.op == IBTX_OP_XMIT_FIELD_IMM) begin
                        cycles <= cycles + CNT_W'(CYC_DIGIT);
                        p_ptr  <= p_ptr - 1'b1;
                        q_ptr  <= q_ptr - 1'b1;
                        imm_idx <= imm_idx + 1'b1;
                        // flagged high-order digit (not units) ends the field
                        if (!(src.flag && (imm_idx != 3'h0 || cur.op == IBTX_OP_XMIT_FIELD
                                && p_ptr != cur.p_addr))) begin
                            state <= (cur.op == IBTX_OP_XMIT_FIELD) ? READ_Q : WRITE_P;
                            // only five Q digits exist; the immediate form never indexes past the high one
                            if (imm_idx != 3'h4) begin
                                src <= cur.q_digits[3'(imm_idx + 3'h1)];
                            end
                        end
                        if (cur.op == IBTX_OP_XMIT_FIELD_IMM && imm_idx == 3'h4) begin
                            state <= TIMING;
                        end
                    end else if (cur.op == IBTX_OP_XMIT_RECORD) begin
                        cycles <= cycles + CNT_W'(CYC_DIGIT);
                        p_ptr  <= p_ptr + 1'b1;
                        q_ptr  <= q_ptr + 1'b1;
                        if ((src.value & MARK_BITS) != MARK_BITS) begin
                            state <= READ_Q;
                        end
                    end
                end
                MF_READ_P: begin
                    mem_req.rd   <= 1'b1;
                    mem_req.addr <= p_ptr;
                    state        <= MF_WAIT_P;
                end
                MF_WAIT_P: begin
                    mem_req.wr    <= 1'b1;
                    mem_req.addr  <= p_ptr;
                    mem_req.wdata <= '{flag: src.flag, value: mem_rdata.value};
                    state         <= src.flag ? MF_WRITE : TIMING;
                    cycles        <= CNT_W'(CYC_LONG);
                end
                MF_WRITE: begin
                    mem_req.wr    <= 1'b1;
                    mem_req.addr  <= q_ptr;
                    mem_req.wdata <= '{flag: 1'b0, value: src.value};
                    state         <= TIMING;
                end
                TIMING: begin
                    // wait_cnt restarts on the start edge, so the count spans the instruction
                    if (wait_cnt >= cycles - 1'b1) begin
                        busy  <= 1'b0;
                        done  <= 1'b1;
                        state <= IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> ibtx_exec_properties.sv
// Purpose: concurrent checks on ibtx_exec indicators and handshake
// Assumes: indicator snapshot follows an event within three cycles
// Notes: bound to every ibtx_exec instance
`timescale 1ns/1ps
`default_nettype none
module ibtx_exec_properties (
    input wire logic                       ref_clk,
    input wire logic                       reset_n,
    input wire logic                       reset_key,
    input wire logic                       start,
    input wire ibtx_pkg::ibtx_instr_type   instr,
    input wire ibtx_pkg::ibtx_event_type   events,
    input wire ibtx_pkg::ibtx_digit_type   mem_rdata,
    input wire logic                       busy,
    input wire logic                       done,
    input wire logic                       branch_taken,
    input wire ibtx_pkg::ibtx_mem_req_type mem_req,
    input wire logic [18:0]                indicators
);
    import ibtx_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // summary indicators
    AST_IND13_OR: assert property (indicators[9] == (indicators[7] | indicators[8]))
        else $error("indicator 13 is not the or of 11 and 12");
    AST_IND19_OR: assert property (indicators[12] ==
        |{indicators[16], indicators[11:10], indicators[5:4]})
        else $error("indicator 19 is not the or of its sources");
    AST_IND39_OR: assert property (indicators[16] == |indicators[15:13])
        else $error("indicator 39 is not the or of 36 to 38");
    // ==========================================
    // event driven indicators
    AST_POS_SET: assert property (events.arith_done && events.result_pos
        && !events.result_zero |-> ##[1:3] indicators[7])
        else $error("indicator 11 not set");
    AST_ZERO_SET: assert property (events.arith_done && events.result_zero
        |-> ##[1:3] indicators[8]) else $error("indicator 12 not set");
    AST_PARITY: assert property (events.even_parity_err |-> ##[1:3] indicators[10])
        else $error("indicator 16 not set");
    AST_LAST_CARD: assert property (events.last_card |-> ##[1:3] indicators[6])
        else $error("indicator 09 not set");
    AST_DISK_ADDR: assert property (events.disk_addr_err |-> ##[1:3] indicators[13])
        else $error("indicator 36 not set");
    AST_CYL_OVF: assert property (events.last_sector && events.sector_cnt_nonzero
        |-> ##[1:3] indicators[15]) else $error("indicator 38 not set");
    AST_SEEK: assert property (events.seek_end |-> ##[1:3] indicators[18])
        else $error("indicator 42 not set");
    // ==========================================
    // instruction handshake
    AST_START_TAKEN: assert property (start && !busy && instr.op != IBTX_OP_NONE
        |=> busy) else $error("start not taken");
    AST_NO_EARLY_DONE: assert property ($rose(busy) |-> !done [*8])
        else $error("done far too early");
endmodule
bind ibtx_exec ibtx_exec_properties u_props (.ref_clk(ref_clk), .reset_n(reset_n),
    .reset_key(reset_key), .start(start), .instr(instr), .events(events),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .branch_taken(branch_taken),
    .mem_req(mem_req), .indicators(indicators));
`default_nettype wire

// >>> ibtx_pkg.sv
// Purpose: shared constants and types for the indicator, branch and transmit executor
// Assumes: digit storage is one digit per address; 200 MHz clock
// Notes: timing counts derived from microsecond figures
// Notes on behaviour
// - branch indicator is chosen by the two-digit code in Q digits eight and nine.
// - indicator 11 sets on positive nonzero result, clears on next arithmetic or reset.
// - indicator 12 sets on zero result, clears on next arithmetic or reset.
// - indicator 13 is unstored, the OR of indicators 11 and 12.
// - indicators 16 and 17 set on even or odd buffer parity errors.
// - indicator 19 is the OR of indicators 06, 07, 16, 17 and 39.
// - testing summary indicators 13 or 19 changes no contributing indicator.
// - last-card indicator 09 sets on final card transfer, clears on test or reset.
// - indicator 36 sets on disk address faults, clears on test, reset or disk operation.
// - indicator 38 sets when last sector finishes with sector count not zero.
// - indicator 39 is the OR of disk indicators 36, 37 and 38.
// - seek-complete indicator 42 sets at seek end, clears on test or power-on reset.
// - branch on indicator takes 200 us when taken, 160 us otherwise.
// - branch if indicator off mirrors branch on, with inverted sense and same timing.
// - branch no group mark branches when Q is not group mark; 240 or 200 us.
// - branch no record mark treats a group mark as a record mark.
// - transmit digit copies digit and flag from Q to P in 200 us.
// - immediate transmit digit copies the instruction's Q units digit and flag to P.
// - transmit field copies downward from Q to P, stopping after the flagged digit.
// - transmit field takes 160 us plus 40 us per source digit.
// - immediate transmit field uses the instruction's own Q digits as source.
// - transmit record copies upward including flags, stopping after the record mark.
// - transmit record takes 160 us plus 40 us per source character.
// - move flag clears P flag if Q unflagged, else moves flag from Q to P.
package ibtx_pkg;
    localparam int unsigned CLK_MHZ        = 200;
    localparam int unsigned T_BASE_US      = 160;
    localparam int unsigned T_DIGIT_US     = 40;
    localparam int unsigned T_SHORT_US     = 200;
    localparam int unsigned T_LONG_US      = 240;
    localparam int unsigned CYC_BASE       = T_BASE_US * CLK_MHZ;
    localparam int unsigned CYC_DIGIT      = T_DIGIT_US * CLK_MHZ;
    localparam int unsigned CYC_SHORT      = T_SHORT_US * CLK_MHZ;
    localparam int unsigned CYC_LONG       = T_LONG_US * CLK_MHZ;
    localparam int unsigned ADDR_W         = 17;
    localparam int unsigned CNT_W          = 24;
    // digit codes: 4-bit value, record mark 4'hA, group mark 4'hF (8 and 2 bits set)
    localparam logic [3:0]  RECORD_MARK    = 4'hA;
    localparam logic [3:0]  GROUP_MARK     = 4'hF;
    localparam logic [3:0]  MARK_BITS      = 4'hA;
    // indicator codes
    localparam logic [7:0]  IND_RD_CHECK   = 8'h06;
    localparam logic [7:0]  IND_WR_CHECK   = 8'h07;
    localparam logic [7:0]  IND_LAST_CARD  = 8'h09;
    localparam logic [7:0]  IND_HIGH_POS   = 8'h11;
    localparam logic [7:0]  IND_EQ_ZERO    = 8'h12;
    localparam logic [7:0]  IND_HP_OR_EZ   = 8'h13;
    localparam logic [7:0]  IND_EVEN_CHK   = 8'h16;
    localparam logic [7:0]  IND_ODD_CHK    = 8'h17;
    localparam logic [7:0]  IND_ANY_CHECK  = 8'h19;
    localparam logic [7:0]  IND_ADDR_CHK   = 8'h36;
    localparam logic [7:0]  IND_WRONG_LEN  = 8'h37;
    localparam logic [7:0]  IND_CYL_OVF    = 8'h38;
    localparam logic [7:0]  IND_ANY_DISK   = 8'h39;
    localparam logic [7:0]  IND_SEEK_DONE  = 8'h42;

    typedef enum logic [3:0] {
        IBTX_OP_NONE, IBTX_OP_BRANCH_ON, IBTX_OP_BRANCH_OFF, IBTX_OP_BRANCH_NO_GROUP,
        IBTX_OP_BRANCH_NO_RECORD, IBTX_OP_XMIT_DIGIT, IBTX_OP_XMIT_DIGIT_IMM,
        IBTX_OP_XMIT_FIELD, IBTX_OP_XMIT_FIELD_IMM, IBTX_OP_XMIT_RECORD, IBTX_OP_MOVE_FLAG
    } ibtx_op_type;

    typedef struct packed {
        logic             flag;
        logic [3:0]       value;
    } ibtx_digit_type;

    typedef struct packed {
        ibtx_op_type      op;
        logic [ADDR_W-1:0] p_addr;
        logic [ADDR_W-1:0] q_addr;
        ibtx_digit_type [4:0] q_digits;  // q_digits[0] is units (Q11), [3] is Q8, [4] Q7
    } ibtx_instr_type;

    typedef struct packed {
        logic             arith_done;
        logic             result_pos;
        logic             result_zero;
        logic             read_err;
        logic             write_err;
        logic             last_card;
        logic             even_parity_err;
        logic             odd_parity_err;
        logic             disk_start;
        logic             disk_addr_err;
        logic             disk_len_err;
        logic             last_sector;
        logic             sector_cnt_nonzero;
        logic             seek_end;
    } ibtx_event_type;

    typedef struct packed {
        logic             rd;
        logic             wr;
        logic [ADDR_W-1:0] addr;
        ibtx_digit_type   wdata;
    } ibtx_mem_req_type;
endpackage

// >>> ibtx_store_model.sv
// Purpose: digit storage seen by ibtx_exec
// Assumes: data answers the registered read in its own cycle, 256 digits from low address bits
// Notes: bench presets contents directly
`timescale 1ns/1ps
`default_nettype none
module ibtx_store_model (
    input  wire logic                       ref_clk,
    input  wire ibtx_pkg::ibtx_mem_req_type mem_req,
    output ibtx_pkg::ibtx_digit_type        mem_rdata
);
    import ibtx_pkg::*;
    ibtx_digit_type mem [0:255];
    ibtx_digit_type rd_q;
    initial begin
        rd_q = '0;
        foreach (mem[i]) mem[i] = '0;
    end
    // ==========================================
    // read and write ports
    // idle cycles toggle so stale data is never mistaken for an answer
    always @(posedge ref_clk) begin
        rd_q <= ~rd_q;
        if (mem_req.wr) mem[mem_req.addr[7:0]] <= mem_req.wdata;
    end
    // the executor registers its request, so the answer must stand in that same cycle
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr[7:0]] : rd_q;
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench for ibtx_exec
// Assumes: full instruction times, so only two instructions are run
// Notes: indicator cases run from a table, instructions by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ibtx_pkg::*;
    typedef struct packed {
        ibtx_event_type ev;
        logic [18:0]    ind;
    } ibtx_row_type;
    logic             ref_clk = 1'b0;
    logic             reset_n;
    logic             reset_key;
    logic             start;
    ibtx_instr_type   instr;
    ibtx_event_type   events;
    ibtx_digit_type   mem_rdata;
    logic             busy;
    logic             done;
    logic             branch_taken;
    ibtx_mem_req_type mem_req;
    logic [18:0]      indicators;
    int               n_fail = 0;
    int               comparisons = 0;
    int               cyc;
    ibtx_row_type     rows [11] = '{{14'h3000, 19'h00280}, {14'h2800, 19'h00300},
        {14'h0400, 19'h01010}, {14'h0200, 19'h01020}, {14'h0100, 19'h00040},
        {14'h0080, 19'h01400}, {14'h0040, 19'h01800}, {14'h0010, 19'h13000},
        {14'h0008, 19'h15000}, {14'h0006, 19'h19000}, {14'h0001, 19'h40000}};
    ibtx_exec dut (.ref_clk(ref_clk), .reset_n(reset_n), .reset_key(reset_key),
        .start(start), .instr(instr), .events(events), .mem_rdata(mem_rdata),
        .busy(busy), .done(done), .branch_taken(branch_taken), .mem_req(mem_req),
        .indicators(indicators));
    ibtx_store_model u_store (.ref_clk(ref_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    always #2.5 ref_clk = ~ref_clk;
    // ==========================================
    // helpers
    task automatic check(input logic [18:0] seen, input logic [18:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input ibtx_op_type op, input logic [16:0] p, input logic [16:0] q);
        instr.op = op;
        instr.p_addr = p;
        instr.q_addr = q;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        cyc = 1;
        while (done !== 1'b1 && cyc < 60000) begin
            @(negedge ref_clk);
            cyc++;
        end
        // an instruction that never ends counts as a mismatch
        if (done !== 1'b1) n_fail++;
    endtask
    task automatic final_report;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        reset_n = 1'b0;
        reset_key = 1'b0;
        start = 1'b0;
        instr = '0;
        events = '0;
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        reset_n = 1'b1;
        foreach (rows[i]) begin
            events = rows[i].ev;
            @(negedge ref_clk);
            events = '0;
            repeat (3) @(negedge ref_clk);
            check(indicators, rows[i].ind);
            reset_key = 1'b1;
            @(negedge ref_clk);
            reset_key = 1'b0;
            @(negedge ref_clk);
        end
        check(indicators, 19'h40000);
        events = 14'h3000;
        @(negedge ref_clk);
        events = '0;
        repeat (3) @(negedge ref_clk);
        // selects indicator 13 while it is on, so the off-test falls through
        instr.q_digits[3].value = 4'h1;
        instr.q_digits[2].value = 4'h3;
        run(IBTX_OP_BRANCH_OFF, 17'h000C8, 17'h00000);
        check(branch_taken, 19'h0);
        check(cyc >= CYC_BASE && cyc <= CYC_BASE + 40, 19'h1);
        check(indicators, 19'h40280);
        @(negedge ref_clk);
        u_store.mem[8'h64] = 5'h05;
        u_store.mem[8'h63] = 5'h13;
        u_store.mem[8'h62] = 5'h19;
        u_store.mem[8'hC6] = 5'h02;
        run(IBTX_OP_XMIT_FIELD, 17'h000C8, 17'h00064);
        repeat (2) @(negedge ref_clk);
        check(u_store.mem[8'hC8], 19'h05);
        check(u_store.mem[8'hC7], 19'h13);
        check(u_store.mem[8'hC6], 19'h02);
        check(u_store.mem[8'h64], 19'h05);
        check(cyc >= CYC_BASE + 2 * CYC_DIGIT && cyc <= CYC_BASE + 2 * CYC_DIGIT + 40, 19'h1);
        reset_n = 1'b0;
        @(negedge ref_clk);
        check(indicators, 19'h0);
        reset_n = 1'b1;
        final_report();
    end
    initial begin
        // tests need about 80100 cycles; give up at 90000
        #450000;
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
